// >>> rtl/rcp_top.sv
// Reset sequencing, reference selection, watchdog and power levels behind an APB slave.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rcp_top (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [rcp_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [2:0] ref_freq_select_straps_i,
  input wire logic watchdog_clock_in_pin_i,
  input wire logic wake_i,
  output logic io_hiz_o,
  output logic cpu_rst_o,
  output logic fw_reload_o,
  output logic [7:0] pll_mult_o,
  output logic ref_ok_o,
  output logic osc_en_o,
  output logic cpu_clk_en_o,
  output logic pll_en_o,
  output logic phy_en_o,
  output logic core_pwr_en_o,
  output logic [2:0] power_level_o,
  output logic irq_o
);
  import rcp_pkg::*;

  rcp_core_s core_reg;
  rcp_core_s core_next;
  logic [15:0] wdt_count;
  logic wdt_expire;
  logic wdt_run;
  logic setup;
  logic wr_done;
  logic [1:0] st_set;
  logic [1:0] st_clr;
  logic mapped;
  logic [31:0] rd_data;

  assign wdt_run = core_reg.wdt_en && !core_reg.io_hiz && core_reg.level != LVL_CORE_PD;

  rcp_wdt u_wdt (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .en_i(wdt_run),
    .ext_sel_i(core_reg.wdt_ext),
    .ext_clk_i(watchdog_clock_in_pin_i),
    .kick_i(core_reg.kick),
    .load_i(core_reg.wdt_load),
    .count_o(wdt_count),
    .expire_o(wdt_expire)
  );

  always_comb begin
    setup = psel_i && !penable_i;
    wr_done = psel_i && penable_i && pwrite_i && core_reg.pready;
    mapped = 1'b1;
    rd_data = 32'h0;
    if (paddr_i == ADDR_INIT_CTRL) begin
      rd_data = {30'h0, core_reg.io_hiz, core_reg.cpu_rst};
    end else if (paddr_i == ADDR_STATUS) begin
      rd_data = {30'h0, core_reg.status};
    end else if (paddr_i == ADDR_MASK) begin
      rd_data = {30'h0, core_reg.mask};
    end else if (paddr_i == ADDR_WDT_CTRL) begin
      rd_data = {29'h0, core_reg.wdt_ext, core_reg.wdt_rst_en, core_reg.wdt_en};
    end else if (paddr_i == ADDR_WDT_LOAD) begin
      rd_data = {16'h0, core_reg.wdt_load};
    end else if (paddr_i == ADDR_WDT_COUNT) begin
      rd_data = {16'h0, wdt_count};
    end else if (paddr_i == ADDR_POWER) begin
      rd_data = {29'h0, core_reg.level};
    end else if (paddr_i == ADDR_CLK_STATUS) begin
      rd_data = {16'h0, core_reg.pll_mult, 2'h0, core_reg.xtal_en, core_reg.clk_ok, 1'b0, core_reg.straps};
    end else begin
      mapped = 1'b0;
    end
  end

  always_comb begin
    core_next = core_reg;
    core_next.kick = 1'b0;
    st_set = 2'h0;
    st_clr = 2'h0;
    if (core_reg.hold_cnt != '0) begin
      // Whole-device reset in progress: everything returns to reset values and the straps are watched.
      core_next = CORE_RST; // [RULE_01] [RULE_04]
      core_next.hold_cnt = core_reg.hold_cnt - HOLD_W'(1);
      core_next.straps = ref_freq_select_straps_i; // [RULE_16]
    end else begin
      core_next.pready = setup;
      core_next.pslverr = setup && !mapped;
      core_next.prdata = (setup && !pwrite_i) ? rd_data : 32'h0;
      if (core_reg.cpu_cnt != '0) begin
        core_next.cpu_cnt = core_reg.cpu_cnt - CPU_W'(1);
      end
      if (wr_done) begin
        if (paddr_i == ADDR_INIT_CTRL) begin
          if (pwdata_i[INIT_DEV_RST_BIT]) begin
            core_next.hold_cnt = HOLD_W'(DEV_RST_CYC); // [RULE_02] [RULE_04] [RULE_05]
          end
          if (pwdata_i[INIT_CPU_RST_BIT]) begin
            core_next.cpu_cnt = CPU_W'(CPU_RST_CYC); // [RULE_02] [RULE_03]
          end
        end else if (paddr_i == ADDR_STATUS) begin
          st_clr = pwdata_i[1:0];
        end else if (paddr_i == ADDR_MASK) begin
          core_next.mask = pwdata_i[1:0];
        end else if (paddr_i == ADDR_WDT_CTRL) begin
          core_next.wdt_en = pwdata_i[WDT_EN_BIT]; // [RULE_11]
          core_next.wdt_rst_en = pwdata_i[WDT_RST_EN_BIT];
          core_next.wdt_ext = pwdata_i[WDT_EXT_BIT]; // [RULE_10]
        end else if (paddr_i == ADDR_WDT_LOAD) begin
          core_next.wdt_load = pwdata_i[15:0];
          core_next.kick = 1'b1;
        end else if (paddr_i == ADDR_POWER) begin
          if (pwdata_i[2:0] <= 3'(LVL_CORE_PD)) begin
            core_next.level = rcp_level_e'(pwdata_i[2:0]); // [RULE_13]
          end
        end
      end
      if (wdt_expire) begin
        st_set[ST_WDT_BIT] = 1'b1; // [RULE_09]
        if (core_reg.wdt_rst_en) begin
          core_next.cpu_cnt = CPU_W'(CPU_RST_CYC); // [RULE_09]
        end
        if (core_reg.level == LVL_STANDBY) begin
          core_next.level = LVL_NORMAL; // [RULE_09]
          st_set[ST_WAKE_BIT] = 1'b1;
        end
      end
      // Suspend and standby keep all state, so a wake simply resumes normal operation.
      if (wake_i && core_reg.level != LVL_NORMAL && core_reg.level != LVL_CORE_PD) begin
        core_next.level = LVL_NORMAL; // [RULE_15]
        st_set[ST_WAKE_BIT] = 1'b1;
      end
      core_next.status = (core_reg.status & ~st_clr) | st_set;
    end
    core_next.pll_mult = pll_mult_f(core_next.straps); // [RULE_06] [RULE_08]
    core_next.clk_ok = core_next.pll_mult != 8'h00; // [RULE_07]
    core_next.xtal_en = core_next.straps == STRAP_XTAL_19M2; // [RULE_06]
    core_next.io_hiz = core_next.hold_cnt != '0; // [RULE_01]
    core_next.cpu_rst = core_next.io_hiz || core_next.cpu_cnt != '0; // [RULE_03]
    core_next.irq = |(core_next.status & core_next.mask);
    core_next.cpu_clk_en = core_next.level == LVL_NORMAL; // [RULE_12]
    core_next.pll_en = core_next.level == LVL_NORMAL; // [RULE_12]
    core_next.phy_en = core_next.level == LVL_NORMAL || core_next.level == LVL_SUSPEND_PHY_ON; // [RULE_13]
    core_next.core_pwr_en = core_next.level != LVL_CORE_PD; // [RULE_13]
  end

  // The sync reset reloads the hold counter, so a pin reset of any length is stretched alike.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      core_reg <= CORE_RST; // [RULE_01] [RULE_14]
    end else begin
      core_reg <= core_next;
    end
  end

  assign prdata_o = core_reg.prdata;
  assign pready_o = core_reg.pready;
  assign pslverr_o = core_reg.pslverr;
  assign io_hiz_o = core_reg.io_hiz;
  assign cpu_rst_o = core_reg.cpu_rst;
  assign fw_reload_o = core_reg.io_hiz;
  assign pll_mult_o = core_reg.pll_mult;
  assign ref_ok_o = core_reg.clk_ok;
  assign osc_en_o = core_reg.xtal_en;
  assign cpu_clk_en_o = core_reg.cpu_clk_en;
  assign pll_en_o = core_reg.pll_en;
  assign phy_en_o = core_reg.phy_en;
  assign core_pwr_en_o = core_reg.core_pwr_en;
  assign power_level_o = core_reg.level;
  assign irq_o = core_reg.irq;

  default clocking rcp_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  hiz_after_pin_a: assert property ($rose(rst_n_i) |-> io_hiz_o [*8]) // [RULE_01]
    else $error("Pins left floating state too early after reset.");
  dev_soft_reset_a: assert property (wr_done && paddr_i == ADDR_INIT_CTRL && pwdata_i[INIT_DEV_RST_BIT]
    |=> ##1 io_hiz_o && cpu_rst_o && core_reg.mask == 2'h0 && !core_reg.wdt_en) // [RULE_04]
    else $error("Device soft reset did not act as a hard reset.");
  cpu_reset_len_a: assert property (wr_done && paddr_i == ADDR_INIT_CTRL && pwdata_i == 32'h1
    |=> ##1 (cpu_rst_o && !io_hiz_o) [*7]) // [RULE_03]
    else $error("Processor reset too short or disturbed the device.");
  straps_frozen_a: assert property (!io_hiz_o && !$past(io_hiz_o) |-> $stable(pll_mult_o) && $stable(osc_en_o)) // [RULE_16]
    else $error("Reference selection changed during operation.");
  pll_26m_a: assert property (!io_hiz_o && core_reg.straps == STRAP_CLK_26M |-> pll_mult_o == PLL_MULT_26M) // [RULE_08]
    else $error("Wrong PLL factor for the 26 MHz reference.");
  xtal_sel_a: assert property (!io_hiz_o |-> osc_en_o == (core_reg.straps == 3'h0) && ref_ok_o == (pll_mult_o != 8'h00)) // [RULE_06]
    else $error("Crystal select disagrees with the straps.");
  normal_clocks_a: assert property (!io_hiz_o && core_reg.level == LVL_NORMAL |-> cpu_clk_en_o && pll_en_o) // [RULE_12]
    else $error("Normal mode without processor clock or PLL.");
  wdt_flag_a: assert property (wdt_expire && !io_hiz_o |=> core_reg.status[ST_WDT_BIT] && (irq_o || !core_reg.mask[0])) // [RULE_09]
    else $error("Watchdog expiry lost its status flag or interrupt.");
  wdt_wake_a: assert property (wdt_expire && !io_hiz_o && core_reg.level == LVL_STANDBY
    |=> power_level_o == 3'(LVL_NORMAL) ##1 cpu_clk_en_o) // [RULE_09]
    else $error("Watchdog did not wake the device from standby.");
  wdt_off_a: assert property (!core_reg.wdt_en [*2] |-> !wdt_expire) // [RULE_11]
    else $error("Disabled watchdog expired.");
  suspend_keep_a: assert property (core_reg.level == LVL_SUSPEND_PHY_ON && !wake_i
    |=> phy_en_o && !cpu_clk_en_o && $stable(core_reg.wdt_load) && $stable(core_reg.mask)) // [RULE_15]
    else $error("Shallow suspend lost state or PHY power.");
  apb_answer_a: assert property (psel_i && !penable_i && !io_hiz_o |=> pready_o) // [RULE_02]
    else $error("APB access phase not answered.");
endmodule : rcp_top
`default_nettype wire

// >>> rtl/rcp_pkg.sv
// Constants, types and the register map of the reset, clock-select and power-mode controller.
// Contract
// RULE_01 - Hard reset pin starts a device reset; all pins float while it lasts.
// RULE_02 - Firmware asks for a soft reset by writing select bits of init_control_reg.
// RULE_03 - Processor reset restarts the program counter and keeps the loaded firmware.
// RULE_04 - Whole-device soft reset acts exactly like the hard reset pin.
// RULE_05 - After a whole-device reset the firmware must be downloaded again.
// RULE_06 - Straps 000/100/101/110/111 pick 19.2 crystal, 19.2, 26, 38.4, 52 MHz.
// RULE_07 - Reference is the 19.2 MHz crystal or one supported external clock.
// RULE_08 - PLL factor follows the reference so core rates stay the same.
// RULE_09 - Watchdog can interrupt, wake the device from standby and reset the processor.
// RULE_10 - Watchdog counts a 32-kHz clock, internal or from its own pin.
// RULE_11 - Firmware can switch the watchdog off completely.
// RULE_12 - Normal mode keeps processor clock and all PLLs running.
// RULE_13 - Four low-power levels exist: suspend with PHY, without PHY, standby, power-down.
// RULE_14 - Power-on reset is held at least 1 ms with stable supplies; the code only stretches the pin by DEV_RST_CYC (16 cycles, 128 ns).
// RULE_15 - Shallow suspend keeps all state and resumes where execution stopped.
// RULE_16 - Straps are sampled only during reset and frozen afterwards.
package rcp_pkg;
  localparam int CLK_HZ = 125000000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int DEV_RST_HOLD_NS = 128;
  localparam int DEV_RST_CYC = (DEV_RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CPU_RST_HOLD_NS = 64;
  localparam int CPU_RST_CYC = (CPU_RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WD_CLK_HZ = 32768;
  localparam int WD_DIV = CLK_HZ / WD_CLK_HZ;
  localparam int HOLD_W = 5;
  localparam int CPU_W = 4;
  localparam int PRE_W = 12;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_INIT_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_WDT_CTRL = 12'h00c;
  localparam logic [ADDR_W-1:0] ADDR_WDT_LOAD = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_WDT_COUNT = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_POWER = 12'h018;
  localparam logic [ADDR_W-1:0] ADDR_CLK_STATUS = 12'h01c;
  localparam int INIT_CPU_RST_BIT = 0;
  localparam int INIT_DEV_RST_BIT = 1;
  localparam int ST_WDT_BIT = 0;
  localparam int ST_WAKE_BIT = 1;
  localparam int WDT_EN_BIT = 0;
  localparam int WDT_RST_EN_BIT = 1;
  localparam int WDT_EXT_BIT = 2;
  localparam logic [15:0] WDT_LOAD_RST = 16'hffff;
  localparam logic [2:0] STRAP_XTAL_19M2 = 3'h0;
  localparam logic [2:0] STRAP_CLK_19M2 = 3'h4;
  localparam logic [2:0] STRAP_CLK_26M = 3'h5;
  localparam logic [2:0] STRAP_CLK_38M4 = 3'h6;
  localparam logic [2:0] STRAP_CLK_52M = 3'h7;
  localparam logic [7:0] PLL_MULT_19M2 = 8'h82;
  localparam logic [7:0] PLL_MULT_26M = 8'h60;
  localparam logic [7:0] PLL_MULT_38M4 = 8'h41;
  localparam logic [7:0] PLL_MULT_52M = 8'h30;

  typedef enum logic [2:0] {
    LVL_NORMAL, LVL_SUSPEND_PHY_ON, LVL_SUSPEND_PHY_OFF, LVL_STANDBY, LVL_CORE_PD
  } rcp_level_e;

  typedef struct packed {
    logic [HOLD_W-1:0] hold_cnt;
    logic [CPU_W-1:0] cpu_cnt;
    logic [2:0] straps;
    logic [7:0] pll_mult;
    logic clk_ok;
    logic xtal_en;
    rcp_level_e level;
    logic [1:0] status;
    logic [1:0] mask;
    logic wdt_en;
    logic wdt_rst_en;
    logic wdt_ext;
    logic [15:0] wdt_load;
    logic kick;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic io_hiz;
    logic cpu_rst;
    logic cpu_clk_en;
    logic pll_en;
    logic phy_en;
    logic core_pwr_en;
  } rcp_core_s;

  localparam rcp_core_s CORE_RST = '{hold_cnt: HOLD_W'(DEV_RST_CYC), cpu_cnt: '0, straps: '0,
    pll_mult: '0, clk_ok: 1'b0, xtal_en: 1'b0, level: LVL_NORMAL, status: 2'h0, mask: 2'h0,
    wdt_en: 1'b0, wdt_rst_en: 1'b0, wdt_ext: 1'b0, wdt_load: WDT_LOAD_RST, kick: 1'b0,
    prdata: 32'h0, pready: 1'b0, pslverr: 1'b0, irq: 1'b0, io_hiz: 1'b1, cpu_rst: 1'b1,
    cpu_clk_en: 1'b0, pll_en: 1'b0, phy_en: 1'b0, core_pwr_en: 1'b1};

  // Multiplier that brings every supported reference to the same PLL output; zero for an unsupported code.
  function automatic logic [7:0] pll_mult_f(input logic [2:0] straps);
    if (straps == STRAP_XTAL_19M2 || straps == STRAP_CLK_19M2) begin
      return PLL_MULT_19M2;
    end else if (straps == STRAP_CLK_26M) begin
      return PLL_MULT_26M;
    end else if (straps == STRAP_CLK_38M4) begin
      return PLL_MULT_38M4;
    end else if (straps == STRAP_CLK_52M) begin
      return PLL_MULT_52M;
    end
    return 8'h00;
  endfunction : pll_mult_f
endpackage : rcp_pkg

// >>> rtl/rcp_wdt.sv
// Watchdog counter running on 32-kHz ticks from an internal divider or the dedicated pin.
`timescale 1ns/1ps
`default_nettype none
module rcp_wdt (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic ext_sel_i,
  input wire logic ext_clk_i,
  input wire logic kick_i,
  input wire logic [15:0] load_i,
  output logic [15:0] count_o,
  output logic expire_o
);
  import rcp_pkg::*;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic ext_prev;
    logic [15:0] count;
    logic expire;
  } rcp_wdt_s;

  rcp_wdt_s wdt_reg;
  rcp_wdt_s wdt_next;
  logic tick;

  // The tick comes from the pin's rising edge or from the divider wrapping.
  always_comb begin
    wdt_next = wdt_reg;
    wdt_next.ext_prev = ext_clk_i;
    wdt_next.expire = 1'b0;
    if (wdt_reg.pre == PRE_W'(WD_DIV - 1)) begin
      wdt_next.pre = '0;
    end else begin
      wdt_next.pre = wdt_reg.pre + PRE_W'(1);
    end
    tick = ext_sel_i ? (ext_clk_i && !wdt_reg.ext_prev) : (wdt_reg.pre == PRE_W'(WD_DIV - 1)); // [RULE_10]
    if (!en_i || kick_i) begin
      wdt_next.count = load_i; // [RULE_11]
    end else if (tick) begin
      if (wdt_reg.count == 16'h0000) begin
        wdt_next.expire = 1'b1;
        wdt_next.count = load_i;
      end else begin
        wdt_next.count = wdt_reg.count - 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wdt_reg <= '{pre: '0, ext_prev: 1'b0, count: WDT_LOAD_RST, expire: 1'b0};
    end else begin
      wdt_reg <= wdt_next;
    end
  end

  assign count_o = wdt_reg.count;
  assign expire_o = wdt_reg.expire;

  wdt_expire_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    en_i && !kick_i && tick && wdt_reg.count == 16'h0000 |=> expire_o) // [RULE_10]
    else $error("Watchdog did not expire at zero count.");
  wdt_disabled_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !en_i |=> !expire_o && count_o == $past(load_i)) // [RULE_11]
    else $error("Disabled watchdog still counts or expires.");
endmodule : rcp_wdt
`default_nettype wire

// >>> rtl/rcp_top_unused_placeholder_none.sv
// Holds no logic; the controller lives in rcp_top and its watchdog in rcp_wdt.

// >>> testbench/rcp_board.sv
// Board model: strap resistors and the optional external 32-kHz watchdog oscillator.
`timescale 1ns/1ps
`default_nettype none
module rcp_board #(
  parameter int HALF_CYC = 1907
) (
  input wire logic ref_clk_i,
  input wire logic [2:0] strap_sel_i,
  input wire logic osc_run_i,
  output logic [2:0] straps_o,
  output logic wd_clk_o
);
  int cnt;
  assign straps_o = strap_sel_i;
  initial begin
    wd_clk_o = 1'b0;
    cnt = 0;
  end
  // The oscillator runs free while powered, as a real 32-kHz source does.
  always @(posedge ref_clk_i) begin
    if (osc_run_i) begin
      if (cnt == HALF_CYC - 1) begin
        cnt <= 0;
        wd_clk_o <= ~wd_clk_o;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : rcp_board
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the reset, clock-select and power-mode controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rcp_pkg::*;
  logic ref_clk_i, rst_n, psel, penable, pwrite, osc_run, wake, wd_clk;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata_o;
  logic [2:0] strap_sel, straps, power_level_o;
  logic [7:0] pll_mult_o;
  logic pready_o, pslverr_o, io_hiz_o, cpu_rst_o, fw_reload_o, ref_ok_o, osc_en_o;
  logic cpu_clk_en_o, pll_en_o, phy_en_o, core_pwr_en_o, irq_o;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;

  rcp_board board (.ref_clk_i(ref_clk_i), .strap_sel_i(strap_sel), .osc_run_i(osc_run), .straps_o(straps),
    .wd_clk_o(wd_clk));
  rcp_top DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .ref_freq_select_straps_i(straps), .watchdog_clock_in_pin_i(wd_clk), .wake_i(wake), .io_hiz_o(io_hiz_o),
    .cpu_rst_o(cpu_rst_o), .fw_reload_o(fw_reload_o), .pll_mult_o(pll_mult_o), .ref_ok_o(ref_ok_o),
    .osc_en_o(osc_en_o), .cpu_clk_en_o(cpu_clk_en_o), .pll_en_o(pll_en_o), .phy_en_o(phy_en_o),
    .core_pwr_en_o(core_pwr_en_o), .power_level_o(power_level_o), .irq_o(irq_o));

  initial ref_clk_i = 1'b0;
  always #4 ref_clk_i = ~ref_clk_i;

  task automatic stop_test();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  function automatic logic sig(input int s);
    case (s)
      0: return io_hiz_o;
      1: return cpu_rst_o;
      2: return irq_o;
      default: return power_level_o == 3'h0;
    endcase
  endfunction : sig

  // Waits at falling edges for a watched output to reach a level, then judges it.
  task automatic wait_sig(input int s, input logic v, input int lim, output int n);
    n = 0;
    @(negedge ref_clk_i);
    while (sig(s) !== v && n < lim) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk_bit(sig(s), v);
  endtask : wait_sig

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    @(negedge ref_clk_i);
    while (pready_o !== 1'b1) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk_word(32'(n), 32'h0);
    r = prdata_o;
    e = pslverr_o;
    @(posedge ref_clk_i);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk_word(r, exp);
    chk_bit(e, 1'b0);
  endtask : rd_chk

  task automatic hard_reset(input logic [2:0] code);
    int n;
    @(posedge ref_clk_i);
    strap_sel <= code;
    rst_n <= 1'b0;
    repeat (16) @(posedge ref_clk_i);
    rst_n <= 1'b1;
    @(negedge ref_clk_i);
    chk_bit(io_hiz_o, 1'b1);
    chk_bit(cpu_rst_o, 1'b1);
    chk_bit(fw_reload_o, 1'b1);
    chk_bit(pll_en_o, 1'b0);
    wait_sig(0, 1'b0, 40, n);
  endtask : hard_reset

  task automatic t_reset_values();
    rd_chk(ADDR_WDT_LOAD, {16'h0, WDT_LOAD_RST});
    rd_chk(ADDR_WDT_CTRL, 32'h0);
    rd_chk(ADDR_STATUS, 32'h0);
    rd_chk(ADDR_MASK, 32'h0);
    rd_chk(ADDR_POWER, 32'h0);
  endtask : t_reset_values

  task automatic t_straps();
    logic [7:0] tab [8];
    logic ok;
    logic xt;
    tab = '{PLL_MULT_19M2, 8'h0, 8'h0, 8'h0, PLL_MULT_19M2, PLL_MULT_26M, PLL_MULT_38M4, PLL_MULT_52M};
    for (int i = 0; i < 8; i++) begin
      ok = (i == 0 || i > 3);
      xt = (i == 0);
      hard_reset(3'(i));
      chk_word({24'h0, pll_mult_o}, {24'h0, tab[i]});
      chk_bit(ref_ok_o, ok);
      chk_bit(osc_en_o, xt);
      rd_chk(ADDR_CLK_STATUS, {16'h0, tab[i], 2'b00, xt, ok, 1'b0, 3'(i)});
      strap_sel <= ~3'(i);
      repeat (4) @(negedge ref_clk_i);
      chk_word({24'h0, pll_mult_o}, {24'h0, tab[i]});
    end
  endtask : t_straps

  task automatic t_unmapped();
    logic [31:0] r;
    logic e;
    wr(ADDR_MASK, 32'h2);
    wr(12'h020, 32'h1);
    apb(1'b0, 12'hff0, 32'h0, r, e);
    chk_word(r, 32'h0);
    chk_bit(e, 1'b1);
    rd_chk(ADDR_MASK, 32'h2);
  endtask : t_unmapped

  task automatic t_cpu_reset();
    int n;
    wr(ADDR_INIT_CTRL, 32'h1);
    wait_sig(1, 1'b1, 10, n);
    chk_bit(io_hiz_o, 1'b0);
    chk_bit(fw_reload_o, 1'b0);
    wait_sig(1, 1'b0, 20, n);
    chk_word(32'(n + 1), 32'(CPU_RST_CYC));
    rd_chk(ADDR_MASK, 32'h2);
  endtask : t_cpu_reset

  task automatic t_dev_reset();
    int n;
    wr(ADDR_WDT_LOAD, 32'h7);
    wr(ADDR_INIT_CTRL, 32'h2);
    wait_sig(0, 1'b1, 10, n);
    chk_bit(fw_reload_o, 1'b1);
    chk_bit(cpu_rst_o, 1'b1);
    wait_sig(0, 1'b0, 40, n);
    rd_chk(ADDR_MASK, 32'h0);
    rd_chk(ADDR_WDT_LOAD, {16'h0, WDT_LOAD_RST});
  endtask : t_dev_reset

  task automatic t_power();
    wr(ADDR_MASK, 32'h1);
    for (int lv = 0; lv < 5; lv++) begin
      wr(ADDR_POWER, 32'(lv));
      repeat (2) @(negedge ref_clk_i);
      chk_word({29'h0, power_level_o}, 32'(lv));
      chk_bit(cpu_clk_en_o, lv == 0);
      chk_bit(pll_en_o, lv == 0);
      chk_bit(phy_en_o, lv < 2);
      chk_bit(core_pwr_en_o, lv != 4);
      if (lv > 0) begin
        @(posedge ref_clk_i);
        wake <= 1'b1;
        @(posedge ref_clk_i);
        wake <= 1'b0;
        repeat (2) @(negedge ref_clk_i);
        chk_bit(power_level_o == 3'h0, lv != 4);
      end
      if (lv < 4) rd_chk(ADDR_MASK, 32'h1);
    end
    rd_chk(ADDR_STATUS, 32'h2);
    hard_reset(STRAP_CLK_26M);
    @(negedge ref_clk_i);
    chk_bit(cpu_clk_en_o, 1'b1);
    chk_bit(pll_en_o, 1'b1);
    wr(ADDR_POWER, 32'h5);
    rd_chk(ADDR_POWER, 32'h0);
  endtask : t_power

  task automatic t_watchdog();
    int n;
    osc_run <= 1'b1;
    wr(ADDR_MASK, 32'h1);
    wr(ADDR_WDT_LOAD, 32'h0);
    wr(ADDR_WDT_CTRL, 32'h5);
    wait_sig(2, 1'b1, 9000, n);
    rd_chk(ADDR_STATUS, 32'h1);
    wr(ADDR_STATUS, 32'h1);
    wait_sig(2, 1'b0, 4, n);
    wr(ADDR_MASK, 32'h0);
    repeat (4000) @(posedge ref_clk_i);
    rd_chk(ADDR_STATUS, 32'h1);
    @(negedge ref_clk_i);
    chk_bit(irq_o, 1'b0);
    wr(ADDR_WDT_CTRL, 32'h7);
    wait_sig(1, 1'b1, 9000, n);
    wr(ADDR_WDT_CTRL, 32'h5);
    wr(ADDR_STATUS, 32'h3);
    wr(ADDR_POWER, 32'h3);
    wait_sig(3, 1'b1, 9000, n);
    rd_chk(ADDR_STATUS, 32'h3);
    wr(ADDR_WDT_CTRL, 32'h4);
    wr(ADDR_WDT_LOAD, 32'h5);
    wr(ADDR_STATUS, 32'h3);
    repeat (8000) @(posedge ref_clk_i);
    rd_chk(ADDR_WDT_COUNT, 32'h5);
    rd_chk(ADDR_STATUS, 32'h0);
    osc_run <= 1'b0;
    wr(ADDR_MASK, 32'h1);
    wr(ADDR_WDT_LOAD, 32'h0);
    wr(ADDR_WDT_CTRL, 32'h1);
    wait_sig(2, 1'b1, 5000, n);
  endtask : t_watchdog

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    strap_sel = STRAP_CLK_26M;
    osc_run = 1'b0;
    wake = 1'b0;
    hard_reset(STRAP_CLK_26M);
    t_reset_values();
    t_straps();
    hard_reset(STRAP_CLK_26M);
    t_unmapped();
    t_cpu_reset();
    t_dev_reset();
    t_power();
    t_watchdog();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
